// ### hw/dco_consts.svh
// offsets, field positions, reset values and timing counts of the dithered clock block
`ifndef DCO_CONSTS_SVH
`define DCO_CONSTS_SVH

// register locations
`define DCO_LOC_DIVCFG 8'h02
`define DCO_LOC_DEPTHID 8'h0d
`define DCO_LOC_COMMIT 8'h3f

// output_divider_config fields
`define DCO_RATE_HI 7
`define DCO_RATE_LO 6
`define DCO_IDLE_BIT 5
`define DCO_EXP_HI 3
`define DCO_EXP_LO 0
`define DCO_DIVCFG_MASK 8'hef

// dither_depth_and_target_id fields
`define DCO_DEPTH_HI 7
`define DCO_DEPTH_LO 6
`define DCO_GATE_BIT 5
`define DCO_CMODE_BIT 3
`define DCO_ID_HI 2
`define DCO_ID_LO 0
`define DCO_DEPTHID_MASK 8'hef

// reset values before the nonvolatile image is loaded
`define DCO_DIVCFG_RST 8'h00
`define DCO_DEPTHID_RST 8'h00

// divider exponent cap
`define DCO_EXP_MAX 4'h8

// timing
`define DCO_CLK_MHZ 100
`define DCO_STAB_MCYC 512
`define DCO_STAB_CYC (`DCO_STAB_MCYC * 2)
`define DCO_DEGL_US 10
`define DCO_DEGL_CYC (`DCO_DEGL_US * `DCO_CLK_MHZ)
`define DCO_NV_WR_MS 20
`define DCO_NV_WR_CYC (`DCO_NV_WR_MS * `DCO_CLK_MHZ * 1000)

// triangle: 64 steps per sweep period, peak code 31
`define DCO_TRI_PEAK 7'sd31

`endif

// ### hw/dco_pkg.sv
// types shared by the dithered clock block
package dco_pkg;

    // one register access from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] loc;
        logic [7:0] data;
    } dco_req_t;

    // register image held in nonvolatile storage
    typedef struct packed {
        logic [7:0] divcfg;
        logic [7:0] depthid;
    } dco_nvimg_t;

endpackage

// ### hw/dco_top.sv
// dithered clock output control: divider, gating, sleep, dither sweep, commit control
`timescale 1ns/1ps
`default_nettype none
`include "dco_consts.svh"

module dco_top
    import dco_pkg::*;
#(
    parameter int unsigned NV_WR_CYC = `DCO_NV_WR_CYC,
    parameter int unsigned DEGL_CYC = `DCO_DEGL_CYC
) (
    input wire logic core_clk, // master clock domain
    input wire logic rst, // power-on reset
    input wire logic sleep_pin_n, // low requests sleep
    input wire logic gate_pin, // hardware output gate
    input wire logic spread_enable_pin, // dither allow
    input wire dco_req_t bus_req, // register access
    input wire logic [2:0] req_target_id, // address bits of the access
    input wire logic bus_stop, // stop condition seen
    output logic bus_ack, // access matches this target
    output logic [7:0] rd_data, // read answer
    input wire dco_nvimg_t nv_image, // stored image
    output dco_nvimg_t nv_wr_image, // image to store
    output logic nv_wr_stb, // start a storage write
    output logic nv_busy, // storage write running
    output logic [2:0] target_id_bits, // own address bits
    output logic mosc_run, // master oscillator on
    output logic signed [8:0] dither_code, // offset to oscillator
    output logic clk_out_o, // output level
    output logic clk_out_oe // output driven
);

    //--------------------------------------------------
    // working registers
    //--------------------------------------------------
    logic [7:0] divcfg_r;
    logic [7:0] depthid_r;
    logic load_done_r;
    logic acc_wr;
    logic acc_rd;
    logic [3:0] exp_eff;
    logic idle_sel;
    logic sw_gate;
    logic cmode;

    // access counts only when addressed and the image is loaded
    assign bus_ack = (bus_req.wr | bus_req.rd) && (req_target_id == target_id_bits);
    assign acc_wr = bus_ack & bus_req.wr & load_done_r;
    assign acc_rd = bus_ack & bus_req.rd & load_done_r;
    assign target_id_bits = depthid_r[`DCO_ID_HI:`DCO_ID_LO];
    assign idle_sel = divcfg_r[`DCO_IDLE_BIT];
    assign sw_gate = depthid_r[`DCO_GATE_BIT];
    assign cmode = depthid_r[`DCO_CMODE_BIT];
    // values above eight decode as eight
    assign exp_eff = (divcfg_r[`DCO_EXP_HI:`DCO_EXP_LO] > `DCO_EXP_MAX) ?
        `DCO_EXP_MAX : divcfg_r[`DCO_EXP_HI:`DCO_EXP_LO];

    // image load on the first edge after reset, then bus writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            divcfg_r <= `DCO_DIVCFG_RST;
            depthid_r <= `DCO_DEPTHID_RST;
            load_done_r <= 1'b0;
        end else if (!load_done_r) begin
            divcfg_r <= nv_image.divcfg & `DCO_DIVCFG_MASK;
            depthid_r <= nv_image.depthid & `DCO_DEPTHID_MASK;
            load_done_r <= 1'b1;
        end else if (acc_wr && bus_req.loc == `DCO_LOC_DIVCFG) begin
            divcfg_r <= bus_req.data & `DCO_DIVCFG_MASK;
        end else if (acc_wr && bus_req.loc == `DCO_LOC_DEPTHID) begin
            depthid_r <= bus_req.data & `DCO_DEPTHID_MASK;
        end
    end

    // read answer held until the next read; unmapped reads give zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (acc_rd) begin
            case (bus_req.loc)
                `DCO_LOC_DIVCFG: rd_data <= divcfg_r;
                `DCO_LOC_DEPTHID: rd_data <= depthid_r;
                default: rd_data <= 8'h00;
            endcase
        end
    end

    //--------------------------------------------------
    // sleep deglitch and start-up hold
    //--------------------------------------------------
    logic sleep_r;
    logic [9:0] degl_cnt_r;
    logic [10:0] stab_cnt_r;
    logic stab_done;

    // pin must disagree with state for the full window before it flips
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sleep_r <= 1'b0;
            degl_cnt_r <= 10'h000;
        end else if (sleep_r == !sleep_pin_n) begin
            degl_cnt_r <= 10'h000;
        end else if (degl_cnt_r == 10'(DEGL_CYC - 1)) begin
            sleep_r <= !sleep_pin_n;
            degl_cnt_r <= 10'h000;
        end else begin
            degl_cnt_r <= degl_cnt_r + 10'h001;
        end
    end

    assign mosc_run = !sleep_r;
    assign stab_done = (stab_cnt_r == 11'(`DCO_STAB_CYC));

    // restarts after every wake so the oscillator settles again
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stab_cnt_r <= 11'h000;
        end else if (sleep_r) begin
            stab_cnt_r <= 11'h000;
        end else if (!stab_done) begin
            stab_cnt_r <= stab_cnt_r + 11'h001;
        end
    end

    //--------------------------------------------------
    // divider and synchronous gate
    //--------------------------------------------------
    logic [8:0] div_cnt_r;
    logic [8:0] div_cnt_nxt;
    logic [8:0] per_mask;
    logic at_start;
    logic gate_want;
    logic en_r;
    logic en_nxt;
    logic out_nxt;
    logic clk_out_oe_nxt;

    // bit zero of the counter is the master clock divided by two
    assign div_cnt_nxt = sleep_r ? 9'h000 : div_cnt_r + 9'h001;
    assign per_mask = 9'((10'h002 << exp_eff) - 10'h001);
    assign at_start = ((div_cnt_nxt & per_mask) == 9'h000);
    assign gate_want = stab_done & (gate_pin | sw_gate);
    // gate changes only where the output is about to start low
    assign en_nxt = sleep_r ? 1'b0 : (at_start ? gate_want : en_r);
    assign out_nxt = en_nxt & div_cnt_nxt[exp_eff];
    assign clk_out_oe_nxt = en_nxt | idle_sel;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt_r <= 9'h000;
            en_r <= 1'b0;
            clk_out_o <= 1'b0;
            clk_out_oe <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            en_r <= en_nxt;
            clk_out_o <= out_nxt;
            clk_out_oe <= clk_out_oe_nxt;
        end
    end

    //--------------------------------------------------
    // triangle dither generator
    //--------------------------------------------------
    logic dith_on;
    logic [1:0] rate_sel;
    logic [1:0] depth_sel;
    logic [7:0] step_cnt_r;
    logic [7:0] step_lim;
    logic [5:0] tri_ph_r;
    logic [4:0] tri_lvl;
    logic signed [6:0] tri_base;
    logic signed [8:0] dith_nxt;

    assign rate_sel = divcfg_r[`DCO_RATE_HI:`DCO_RATE_LO];
    assign depth_sel = depthid_r[`DCO_DEPTH_HI:`DCO_DEPTH_LO];
    assign dith_on = (rate_sel != 2'b00) & spread_enable_pin & !sleep_r;
    // 64 steps per sweep: n/64 core cycles per step
    assign step_lim = 8'((16'h0020 << rate_sel) - 16'h0001);
    assign tri_lvl = tri_ph_r[5] ? ~tri_ph_r[4:0] : tri_ph_r[4:0];
    // odd codes -31..31 keep the sweep centred on zero
    assign tri_base = $signed({1'b0, tri_lvl, 1'b0}) - `DCO_TRI_PEAK;
    assign dith_nxt = dith_on ? (9'(tri_base) <<< depth_sel) : 9'sh000;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            step_cnt_r <= 8'h00;
            tri_ph_r <= 6'h00;
            dither_code <= 9'sh000;
        end else begin
            dither_code <= dith_nxt;
            if (!dith_on) begin
                step_cnt_r <= 8'h00;
                tri_ph_r <= 6'h00;
            end else if (step_cnt_r >= step_lim) begin
                step_cnt_r <= 8'h00;
                tri_ph_r <= tri_ph_r + 6'h01;
            end else begin
                step_cnt_r <= step_cnt_r + 8'h01;
            end
        end
    end

    //--------------------------------------------------
    // nonvolatile commit control
    //--------------------------------------------------
    logic set_pend;
    logic pend_r;
    logic go_r;
    logic nv_start;
    logic [21:0] nv_cnt_r;

    // depth/id and the command always store; config stores only in auto mode
    assign set_pend = acc_wr & ((bus_req.loc == `DCO_LOC_DIVCFG && !cmode) ||
        bus_req.loc == `DCO_LOC_DEPTHID ||
        bus_req.loc == `DCO_LOC_COMMIT);
    // waits for the stop and for any earlier write to finish
    assign nv_start = go_r & !nv_busy;

    // new writes win over the clear of the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
            go_r <= 1'b0;
        end else begin
            pend_r <= set_pend | (pend_r & !nv_start);
            go_r <= (bus_stop & (pend_r | set_pend)) | (go_r & !nv_start);
        end
    end

    // snapshot of the image, then the busy window
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nv_wr_stb <= 1'b0;
            nv_busy <= 1'b0;
            nv_cnt_r <= 22'h00_0000;
            nv_wr_image <= '0;
        end else begin
            nv_wr_stb <= nv_start;
            if (nv_start) begin
                nv_busy <= 1'b1;
                nv_cnt_r <= 22'h00_0000;
                nv_wr_image <= {divcfg_r, depthid_r};
            end else if (nv_busy) begin
                nv_cnt_r <= nv_cnt_r + 22'h00_0001;
                nv_busy <= (nv_cnt_r != 22'(NV_WR_CYC - 1));
            end
        end
    end

    //--------------------------------------------------
    // checks
    //--------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_auto_wr;
        acc_wr && bus_req.loc == `DCO_LOC_DIVCFG && !cmode && !pend_r && !go_r && !nv_busy;
    endsequence
    sequence s_stop_free;
        bus_stop && !nv_busy;
    endsequence

    chk_exp_cap: assert property (exp_eff <= `DCO_EXP_MAX &&
        (divcfg_r[3:0] > 4'h8 -> exp_eff == 4'h8)) else $error("divider exponent not capped");
    chk_div_count: assert property (!sleep_r |=> div_cnt_r == $past(div_cnt_r) + 9'h001)
        else $error("master clock not running while awake");
    chk_stab_hold: assert property (!stab_done |-> !en_r && !clk_out_o)
        else $error("output enabled before start-up count");
    chk_sleep_off: assert property (sleep_r |=> !clk_out_o && !en_r && div_cnt_r == 9'h000)
        else $error("output or oscillator active in sleep");
    chk_gate_or: assert property (at_start && !sleep_r && stab_done && (gate_pin || sw_gate) |=> en_r)
        else $error("gate did not enable output");
    chk_out_cause: assert property (clk_out_o |-> en_r && !$past(sleep_r) && $past(stab_done))
        else $error("output driven without gate");
    chk_sync_en: assert property ($rose(en_r) |-> !clk_out_o && $past(at_start) && $past(gate_want))
        else $error("enable not aligned to period start");
    chk_dither_off: assert property (!dith_on |=> dither_code == 9'sh000)
        else $error("dither active while disabled");
    chk_dither_span: assert property ($past(dith_on) |-> dither_code <= (9'sd31 <<< $past(depth_sel)) &&
        dither_code >= -(9'sd31 <<< $past(depth_sel))) else $error("dither beyond selected depth");
    chk_idle_drive: assert property (!en_r && !$past(en_r) ##1 !en_r |-> clk_out_oe == $past(idle_sel))
        else $error("idle drive state wrong");
    chk_auto_commit: assert property (s_auto_wr ##1 s_stop_free |=> ##1 nv_wr_stb)
        else $error("auto store missing after write");
    chk_held_commit: assert property (acc_wr && bus_req.loc == `DCO_LOC_DIVCFG && cmode && !pend_r
        |=> !pend_r) else $error("store armed in command mode");
    chk_id_commit: assert property (acc_wr && bus_req.loc == `DCO_LOC_DEPTHID |=> pend_r)
        else $error("depth/id write not stored");
    chk_cmd_commit: assert property (acc_wr && bus_req.loc == `DCO_LOC_COMMIT |=> pend_r)
        else $error("store command ignored");
    chk_target_ack: assert property (req_target_id != target_id_bits |-> !bus_ack)
        else $error("ack for other target");
    chk_nv_busy: assert property (nv_wr_stb |-> nv_busy && nv_wr_image == $past({divcfg_r, depthid_r}))
        else $error("store started without busy");
    chk_power_load: assert property (!load_done_r |=> divcfg_r == ($past(nv_image.divcfg) & 8'hef))
        else $error("image not loaded at power-on");

endmodule // dco_top

`default_nettype wire

// ### testbench/dco_host_model.sv
// serial bus controller model issuing register accesses to the clock block
`timescale 1ns/1ps
`default_nettype none

module dco_host_model
    import dco_pkg::*;
(
    input wire logic core_clk, // master clock
    output dco_req_t bus_req, // register access
    output logic [2:0] req_target_id, // address bits
    output logic bus_stop, // stop condition
    input wire logic bus_ack, // target answered
    input wire logic [7:0] rd_data // read answer
);
    // idle bus at time zero
    initial begin
        bus_req = '0;
        req_target_id = 3'h0;
        bus_stop = 1'b0;
    end

    // one access, location and data in one pulse, optional stop after it
    task automatic xfer(input logic w, input logic [7:0] loc, input logic [7:0] d, input logic [2:0] id,
        input logic stp, output logic ack, output logic [7:0] rdv);
        @(negedge core_clk);
        bus_req = '{wr: w, rd: !w, loc: loc, data: d};
        req_target_id = id;
        @(posedge core_clk);
        ack = bus_ack;
        @(negedge core_clk);
        rdv = rd_data;
        // released lines flip so a stale value cannot pass for a live one
        bus_req = '{wr: 1'b0, rd: 1'b0, loc: ~loc, data: ~d};
        req_target_id = ~id;
        bus_stop = stp;
        @(negedge core_clk);
        bus_stop = 1'b0;
    endtask
endmodule // dco_host_model

`default_nettype wire

// ### testbench/tb_dithered_clock_output_control.sv
// self-checking bench for the dithered clock output control block
`timescale 1ns/1ps
`default_nettype none
`include "dco_consts.svh"

module tb_dithered_clock_output_control
    import dco_pkg::*;
;
    logic core_clk, rst, sleep_pin_n, gate_pin, spread_enable_pin, bus_stop, bus_ack, ack;
    logic nv_wr_stb, nv_busy, mosc_run, clk_out_o, clk_out_oe;
    logic [2:0] req_target_id, target_id_bits;
    logic [7:0] rd_data, rdv;
    logic signed [8:0] dither_code, dmin, dmax;
    dco_req_t bus_req;
    dco_nvimg_t nv_image, nv_wr_image;
    int cyc, n_stb, blen, busy_len, n_errors, check_count;

    // short store and sense counts keep the run brief
    dco_top #(.NV_WR_CYC(20), .DEGL_CYC(4)) dco_top_inst (.core_clk(core_clk), .rst(rst),
        .sleep_pin_n(sleep_pin_n), .gate_pin(gate_pin), .spread_enable_pin(spread_enable_pin),
        .bus_req(bus_req), .req_target_id(req_target_id), .bus_stop(bus_stop), .bus_ack(bus_ack),
        .rd_data(rd_data), .nv_image(nv_image), .nv_wr_image(nv_wr_image), .nv_wr_stb(nv_wr_stb),
        .nv_busy(nv_busy), .target_id_bits(target_id_bits), .mosc_run(mosc_run),
        .dither_code(dither_code), .clk_out_o(clk_out_o), .clk_out_oe(clk_out_oe));
    dco_host_model dco_host_model_inst (.core_clk(core_clk), .bus_req(bus_req),
        .req_target_id(req_target_id), .bus_stop(bus_stop), .bus_ack(bus_ack), .rd_data(rd_data));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // cycle count since reset, store pulses and busy run length
    always @(posedge core_clk or posedge rst) begin
        if (rst) cyc <= 0;
        else cyc <= cyc + 1;
    end
    always @(posedge core_clk) begin
        if (nv_wr_stb === 1'b1) n_stb <= n_stb + 1;
        if (nv_busy === 1'b1) blen <= blen + 1;
        else if (blen != 0) begin
            busy_len <= blen;
            blen <= 0;
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] loc, input logic [7:0] d, input logic [2:0] id,
        input logic stp);
        dco_host_model_inst.xfer(w, loc, d, id, stp, ack, rdv);
    endtask
    // output edges are seen at the falling edge, after the register has settled
    task automatic next_edge(input logic lvl, output int t);
        logic p;
        do begin
            p = clk_out_o;
            @(negedge core_clk);
        end while (clk_out_o !== lvl || p !== !lvl);
        t = cyc;
    endtask
    task automatic to_peak(input logic signed [8:0] pk, output int t);
        logic signed [8:0] p;
        do begin
            p = dither_code;
            @(negedge core_clk);
            if (dither_code < dmin) dmin = dither_code;
            if (dither_code > dmax) dmax = dither_code;
        end while (dither_code !== pk || p === pk);
        t = cyc;
    endtask
    task automatic store_case(input logic [7:0] loc, input logic [7:0] d, input int n, input logic [15:0] img);
        int n0;
        n0 = n_stb;
        acc(1, loc, d, 3'h5, 1);
        repeat (40) @(negedge core_clk);
        chk_val("stores", 16'(n), 16'(n_stb - n0));
        if (n != 0) chk_val("image", img, nv_wr_image);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_startup();
        int t;
        repeat (500) @(negedge core_clk);
        chk_val("oe_idle", 1, clk_out_oe);
        chk_val("out_idle", 0, clk_out_o);
        next_edge(1'b1, t);
        chk_val("start", 1, t >= 1024 && t <= 1060);
    endtask
    task automatic t_regs();
        acc(0, `DCO_LOC_DIVCFG, 8'h00, 3'h5, 0);
        chk_val("ack", 1, ack);
        chk_val("divcfg", 8'h21, rdv);
        acc(0, `DCO_LOC_DEPTHID, 8'h00, 3'h5, 0);
        chk_val("depthid", 8'h0d, rdv);
        chk_val("target", 3'h5, target_id_bits);
        acc(1, `DCO_LOC_DIVCFG, 8'h2f, 3'h2, 0);
        chk_val("nack", 0, ack);
        acc(0, `DCO_LOC_DIVCFG, 8'h00, 3'h5, 0);
        chk_val("kept", 8'h21, rdv);
        acc(0, `DCO_LOC_COMMIT, 8'h00, 3'h5, 0);
        chk_val("cmd_read", 0, rdv);
        acc(1, `DCO_LOC_DEPTHID, 8'h0b, 3'h5, 0);
        acc(0, `DCO_LOC_DEPTHID, 8'h00, 3'h3, 0);
        chk_val("new_id", 1, ack);
        acc(1, `DCO_LOC_DEPTHID, 8'h0d, 3'h3, 0);
    endtask
    task automatic t_sleep();
        int t0, t;
        sleep_pin_n = 1'b0;
        repeat (30) @(negedge core_clk);
        chk_val("osc_off", 0, mosc_run);
        chk_val("slp_out", 0, clk_out_o);
        chk_val("slp_oe", 1, clk_out_oe);
        t0 = cyc;
        sleep_pin_n = 1'b1;
        next_edge(1'b1, t);
        chk_val("wake", 1, t - t0 >= 1024 && t - t0 <= 1100);
    endtask
    task automatic t_gating();
        logic o, tog;
        for (int k = 0; k < 8; k++) begin
            acc(1, `DCO_LOC_DIVCFG, {2'b00, k[2], 5'h01}, 3'h5, 0);
            acc(1, `DCO_LOC_DEPTHID, {2'b00, k[1], 5'h0d}, 3'h5, 0);
            gate_pin = k[0];
            repeat (16) @(negedge core_clk);
            o = clk_out_o;
            tog = 1'b0;
            chk_val("gate_oe", (k[0] | k[1]) ? 1'b1 : k[2], clk_out_oe);
            chk_val("osc_run", 1, mosc_run);
            repeat (8) begin
                @(negedge core_clk);
                tog |= (clk_out_o !== o);
            end
            chk_val("gate_run", k[0] | k[1], tog);
        end
    endtask
    task automatic t_sync_period();
        int a, b, c, m;
        logic [3:0] e;
        acc(1, `DCO_LOC_DIVCFG, 8'h22, 3'h5, 0);
        acc(1, `DCO_LOC_DEPTHID, 8'h0d, 3'h5, 0);
        gate_pin = 1'b0;
        repeat (20) @(negedge core_clk);
        gate_pin = 1'b1;
        next_edge(1'b1, a);
        next_edge(1'b0, b);
        chk_val("first_high", 4, 16'(b - a));
        for (int i = 0; i < 4; i++) begin
            e = (i == 3) ? 4'hf : 4'(4 * i);
            m = (e > 8) ? 8 : int'(e);
            acc(1, `DCO_LOC_DIVCFG, {4'h2, e}, 3'h5, 0);
            next_edge(1'b1, a);
            next_edge(1'b1, a);
            next_edge(1'b0, b);
            next_edge(1'b1, c);
            chk_val("high", 16'(1 << m), 16'(b - a));
            chk_val("period", 16'(2 << m), 16'(c - a));
        end
    endtask
    task automatic t_store();
        store_case(`DCO_LOC_DEPTHID, 8'h0d, 1, 16'h2f0d);
        chk_val("busy_len", 20, 16'(busy_len));
        store_case(`DCO_LOC_DIVCFG, 8'h23, 0, 16'h0000);
        store_case(`DCO_LOC_COMMIT, 8'h00, 1, 16'h230d);
        store_case(8'h10, 8'hff, 0, 16'h0000);
        store_case(`DCO_LOC_DEPTHID, 8'h05, 1, 16'h2305);
        store_case(`DCO_LOC_DIVCFG, 8'h24, 1, 16'h2405);
    endtask
    task automatic t_dither();
        int a, b;
        logic [1:0] r;
        logic nz;
        logic signed [8:0] pk;
        acc(1, `DCO_LOC_DIVCFG, 8'h21, 3'h5, 0);
        for (int j = 0; j < 2; j++) begin
            spread_enable_pin = !j[0];
            nz = 1'b0;
            repeat (300) begin
                @(negedge core_clk);
                nz |= (dither_code !== 9'sd0);
            end
            chk_val("no_dither", 0, nz);
            acc(1, `DCO_LOC_DIVCFG, 8'h61, 3'h5, 0);
        end
        spread_enable_pin = 1'b1;
        for (int i = 0; i < 4; i++) begin
            r = (i == 3) ? 2'd1 : 2'(i + 1);
            pk = 9'sd31 <<< i;
            acc(1, `DCO_LOC_DIVCFG, {r, 6'h21}, 3'h5, 0);
            acc(1, `DCO_LOC_DEPTHID, {2'(i), 6'h05}, 3'h5, 0);
            to_peak(pk, a);
            dmin = 9'sd0;
            dmax = 9'sd0;
            to_peak(pk, b);
            chk_val("sweep", 16'(4096 << (r - 1)), 16'(b - a));
            chk_val("dev_low", -pk, dmin);
            chk_val("dev_high", pk, dmax);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // main sequence; the stored image selects commit on command only
    initial begin
        rst = 1'b1;
        sleep_pin_n = 1'b1;
        gate_pin = 1'b1;
        spread_enable_pin = 1'b0;
        nv_image = '{divcfg: 8'h31, depthid: 8'h1d};
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        t_startup();
        t_regs();
        t_sleep();
        t_gating();
        t_sync_period();
        t_store();
        t_dither();
        summarize();
    end

    // watchdog well beyond the expected run of some 70k cycles
    initial begin
        #950_000;
        n_errors++;
        summarize();
    end
endmodule // tb_dithered_clock_output_control

`default_nettype wire
